// file: hw/ret_pkg.sv
// constants, types and decode helpers for the subroutine return logic
// Notes on behaviour
// - literal return writes its 8-bit immediate into the working register, then returns.
// - plain return pops one entry, reducing a nonzero return stack depth by one.
// - on return the program counter takes the stack top entry address.
// - return takes two instruction cycles; decode and pop, then an idle refill cycle.
package ret_pkg;

  // ==========================================================================
  // sizes and reset values
  localparam int STACK_LEVELS = 8;
  localparam int PC_WIDTH = 13;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // ==========================================================================
  // quarter phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam int CLOCKS_PER_INSTR = 4;

  // ==========================================================================
  // opcode patterns
  localparam logic [13:0] LIT_RET_MASK = 14'h3c00;
  localparam logic [13:0] LIT_RET_MATCH = 14'h3400;
  localparam logic [13:0] PLAIN_RET_CODE = 14'h0008;
  localparam int LIT_LSB = 0;

  typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_RET} ret_op_t;
  typedef enum logic {ST_RUN, ST_FLUSH} ctl_state_t;

  // results of one retired return, as seen by the core
  typedef struct packed {
    logic w_we;
    logic [7:0] w;
    logic pc_load;
    logic flush;
  } retire_t;

  function automatic logic is_literal_return_op(input logic [13:0] word);
    return (word & LIT_RET_MASK) == LIT_RET_MATCH;
  endfunction

  function automatic logic is_plain_return(input logic [13:0] word);
    return word == PLAIN_RET_CODE;
  endfunction

endpackage

// file: hw/qphase_gen.sv
// quarter-phase divider: one instruction cycle is four clock cycles
module qphase_gen
  import ret_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  output logic [1:0] phase
);

  typedef struct packed {
    logic [1:0] phase;
  } qst_t;

  qst_t st;
  qst_t next_st;

  // ==========================================================================
  // phase counter
  always_comb
  begin
    next_st = st;
    next_st.phase = st.phase + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st.phase <= PHASE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign phase = st.phase;

endmodule // qphase_gen

// file: hw/subroutine_return_exec.sv
// execution of the literal return and plain return instructions with the return stack
module subroutine_return_exec
  import ret_pkg::*;
#(
  parameter int DEPTH = STACK_LEVELS,
  parameter int PC_W = PC_WIDTH
)
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic INSTR_VALID,
  input wire logic [13:0] INSTR_WORD,
  input wire logic CALL_PUSH,
  input wire logic [PC_W-1:0] CALL_ADDR,
  output logic [1:0] Q_PHASE,
  output logic [7:0] W_DATA,
  output logic W_WE,
  output logic [PC_W-1:0] PC_VALUE,
  output logic PC_LOAD,
  output logic FETCH_FLUSH,
  output logic [$clog2(DEPTH):0] STACK_DEPTH,
  output logic STATUS_WE
);

  localparam int SP_W = $clog2(DEPTH);
  localparam logic [SP_W:0] DEPTH_FULL = (SP_W + 1)'(DEPTH);

  typedef struct packed {
    ctl_state_t state;
    ret_op_t op;
    logic [7:0] lit;
    retire_t ret;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [SP_W:0] depth;
    logic [DEPTH-1:0][PC_W-1:0] mem;
  } st_t;

  st_t st;
  st_t next_st;
  logic [1:0] q;
  logic [SP_W-1:0] top_idx;
  logic [PC_W-1:0] stack_top_entry;

  // ==========================================================================
  // instruction cycle phases
  qphase_gen u_qphase (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .phase(q)
  );

  assign top_idx = st.sp - 1'b1;
  assign stack_top_entry = st.mem[top_idx];

  // ==========================================================================
  // decode and execute
  always_comb
  begin
    next_st = st;
    next_st.ret.w_we = 1'b0;
    next_st.ret.pc_load = 1'b0;
    case (st.state)
      ST_RUN:
      begin
        if (q == PH_Q1 && INSTR_VALID)
        begin
          if (is_literal_return_op(INSTR_WORD))
          begin
            next_st.op = OP_LIT;
          end
          else if (is_plain_return(INSTR_WORD))
          begin
            next_st.op = OP_RET;
          end
          else
          begin
            next_st.op = OP_NONE;
          end
        end
        if (q == PH_Q2 && st.op == OP_LIT)
        begin
          next_st.lit = INSTR_WORD[LIT_LSB +: 8];
        end
        if (q == PH_Q4 && st.op != OP_NONE)
        begin
          if (st.op == OP_LIT)
          begin
            next_st.ret.w = st.lit;
            next_st.ret.w_we = 1'b1;
          end
          next_st.pc = stack_top_entry;
          next_st.ret.pc_load = 1'b1;
          next_st.sp = top_idx;
          if (st.depth != '0)
          begin
            next_st.depth = st.depth - 1'b1;
          end
          next_st.op = OP_NONE;
          next_st.state = ST_FLUSH;
          next_st.ret.flush = 1'b1;
        end
      end
      ST_FLUSH:
      begin
        // second cycle: word fetched meanwhile is discarded
        if (q == PH_Q4)
        begin
          next_st.state = ST_RUN;
          next_st.ret.flush = 1'b0;
        end
      end
      default:
      begin
        next_st.state = ST_RUN;
        next_st.op = OP_NONE;
        next_st.ret.flush = 1'b0;
      end
    endcase
    // a call from elsewhere in the core pushes only when no return is retiring
    if (q == PH_Q4 && st.op == OP_NONE && CALL_PUSH)
    begin
      next_st.mem[st.sp] = CALL_ADDR;
      next_st.sp = st.sp + 1'b1;
      if (st.depth != DEPTH_FULL)
      begin
        next_st.depth = st.depth + 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      st <= '0;
      st.ret.w <= W_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // outputs
  assign Q_PHASE = q;
  assign W_DATA = st.ret.w;
  assign W_WE = st.ret.w_we;
  assign PC_VALUE = st.pc;
  assign PC_LOAD = st.ret.pc_load;
  assign FETCH_FLUSH = st.ret.flush;
  assign STACK_DEPTH = st.depth;
  assign STATUS_WE = 1'b0;

  // ==========================================================================
  // checks
  logic dec_lit;
  logic dec_ret;
  assign dec_lit = q == PH_Q1 && INSTR_VALID && st.state == ST_RUN
    && is_literal_return_op(INSTR_WORD);
  assign dec_ret = q == PH_Q1 && INSTR_VALID && st.state == ST_RUN
    && is_plain_return(INSTR_WORD);

  sequence s_retire;
    ##4 PC_LOAD && FETCH_FLUSH;
  endsequence

  sequence s_idle_cycle;
    (FETCH_FLUSH && !W_WE && !PC_LOAD) [*3] ##1 !FETCH_FLUSH;
  endsequence

  a_literal_to_w: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dec_lit |-> ##4 W_WE && W_DATA == $past(INSTR_WORD[7:0], 3))
    else $error("literal return did not load W");

  a_plain_keeps_w: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dec_ret |-> ##4 !W_WE && W_DATA == $past(W_DATA, 4))
    else $error("plain return changed W");

  a_pop_depth: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (dec_ret || dec_lit) && st.depth != '0 |-> ##4 STACK_DEPTH == $past(STACK_DEPTH, 4) - 1'b1)
    else $error("return did not pop one level");

  a_pc_from_top: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dec_ret || dec_lit |-> ##4 PC_VALUE == $past(stack_top_entry, 4))
    else $error("program counter not loaded from stack top");

  a_two_cycles: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    dec_ret || dec_lit |-> s_retire ##1 s_idle_cycle)
    else $error("return did not take exactly two instruction cycles");

  a_no_flags: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PC_LOAD |-> !STATUS_WE)
    else $error("return touched status flags");

  // push side: a push taken at Q4 below full depth grows the depth unless a return retires there
  sequence s_push_req;
    Q_PHASE == PH_Q4 && CALL_PUSH && STACK_DEPTH != DEPTH_FULL;
  endsequence

  a_push_depth: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_push_req |=> PC_LOAD || STACK_DEPTH == $past(STACK_DEPTH) + 1'b1)
    else $error("accepted push did not add one level");

  a_depth_bound: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    STACK_DEPTH <= DEPTH_FULL)
    else $error("stack depth above its levels");

  a_w_with_return: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    W_WE |-> PC_LOAD)
    else $error("working register written without a return");

  a_load_one_cycle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PC_LOAD |=> !PC_LOAD && !W_WE)
    else $error("return pulses lasted more than one clock");

  a_load_at_q1: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    PC_LOAD |-> Q_PHASE == PH_Q1)
    else $error("return retired off the instruction cycle boundary");

  a_flush_no_decode: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    FETCH_FLUSH && Q_PHASE == PH_Q1 |-> ##4 !PC_LOAD)
    else $error("word offered in the idle cycle was executed");

endmodule // subroutine_return_exec

// file: bench/tb_top.sv
// self-checking bench for the subroutine return logic
module tb_top;
  import ret_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // clock, reset and design
  logic REF_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic INSTR_VALID = 1'b0;
  logic [13:0] INSTR_WORD = 14'h0000;
  logic CALL_PUSH = 1'b0;
  logic [12:0] CALL_ADDR = 13'h0000;
  logic [1:0] Q_PHASE;
  logic [7:0] W_DATA;
  logic W_WE;
  logic [12:0] PC_VALUE;
  logic PC_LOAD;
  logic FETCH_FLUSH;
  logic [3:0] STACK_DEPTH;
  logic STATUS_WE;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [12:0] stk[$];

  subroutine_return_exec dut_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .INSTR_VALID(INSTR_VALID),
    .INSTR_WORD(INSTR_WORD), .CALL_PUSH(CALL_PUSH), .CALL_ADDR(CALL_ADDR), .Q_PHASE(Q_PHASE),
    .W_DATA(W_DATA), .W_WE(W_WE), .PC_VALUE(PC_VALUE), .PC_LOAD(PC_LOAD),
    .FETCH_FLUSH(FETCH_FLUSH), .STACK_DEPTH(STACK_DEPTH), .STATUS_WE(STATUS_WE));

  initial
  begin
    forever #20 REF_CLK = ~REF_CLK;
  end

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_ph(input logic [1:0] ph);
    do @(negedge REF_CLK); while (Q_PHASE !== ph);
  endtask

  task automatic offer(input logic [13:0] word);
    wait_ph(PH_Q1);
    INSTR_VALID = 1'b1;
    INSTR_WORD = word;
    // word held through the quarter that reads the literal
    repeat (2) @(negedge REF_CLK);
    INSTR_VALID = 1'b0;
  endtask

  task automatic do_ret(input logic [13:0] word, input logic lit, input logic [7:0] k);
    logic [12:0] top;
    logic [3:0] depth;
    top = stk.pop_back();
    depth = 4'(stk.size());
    offer(word);
    repeat (2) @(negedge REF_CLK);
    check("w_we", W_WE, lit);
    if (lit)
      check("w_data", W_DATA, k);
    check("pc_load", PC_LOAD, 1'b1);
    check("pc_value", PC_VALUE, top);
    check("depth", STACK_DEPTH, depth);
    check("flush", FETCH_FLUSH, 1'b1);
    check("status_we", STATUS_WE, 1'b0);
    // offer the same word again in the idle cycle; it must be dropped
    INSTR_VALID = 1'b1;
    @(negedge REF_CLK);
    INSTR_VALID = 1'b0;
    check("pulses", {W_WE, PC_LOAD}, 2'h0);
    repeat (2) @(negedge REF_CLK);
    check("flush_held", FETCH_FLUSH, 1'b1);
    @(negedge REF_CLK);
    check("flush_end", FETCH_FLUSH, 1'b0);
    check("idle_no_load", PC_LOAD, 1'b0);
    check("idle_depth", STACK_DEPTH, depth);
  endtask

  // ==========================================================================
  // scenarios
  task automatic sc_push_three();
    logic [12:0] a[3] = '{13'h0123, 13'h1fff, 13'h0aa5};
    foreach (a[i])
    begin
      wait_ph(PH_Q4);
      CALL_PUSH = 1'b1;
      CALL_ADDR = a[i];
      @(negedge REF_CLK);
      CALL_PUSH = 1'b0;
      stk.push_back(a[i]);
      check("push_depth", STACK_DEPTH, 4'(i + 1));
    end
  endtask

  task automatic sc_lit_return();
    do_ret(14'h3700, 1'b1, 8'h00);
    do_ret(14'h34ff, 1'b1, 8'hff);
  endtask

  task automatic sc_plain_return();
    do_ret(PLAIN_RET_CODE, 1'b0, 8'h00);
    check("w_kept", W_DATA, 8'hff);
  endtask

  task automatic sc_bad_opcodes();
    logic [13:0] w[3] = '{14'h0009, 14'h3800, 14'h0408};
    logic seen;
    foreach (w[i])
    begin
      seen = 1'b0;
      offer(w[i]);
      repeat (6)
      begin
        @(negedge REF_CLK);
        seen = seen | PC_LOAD | W_WE;
      end
      check("ignored", seen, 1'b0);
      check("ignored_depth", STACK_DEPTH, 4'(stk.size()));
    end
  endtask

  // ==========================================================================
  // run control
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(negedge REF_CLK);
    check("reset_out", {W_WE, PC_LOAD, FETCH_FLUSH, STACK_DEPTH}, 7'h00);
    RST_B = 1'b1;
    sc_push_three();
    sc_lit_return();
    sc_bad_opcodes();
    sc_plain_return();
    end_of_test();
  end
endmodule // tb_top
